// file: core/pmbus_wp_consts.svh
// Purpose: Command codes, field positions, reset values for the write-protect and addressing block
// Assumes: Included by the package and every module that needs the numbers
// Notes:   Guarded against double inclusion
`ifndef PMBUS_WP_CONSTS_SVH
`define PMBUS_WP_CONSTS_SVH

// Command codes handled or screened here
`define CMD_PAGE            8'h00
`define CMD_OPERATION       8'h01
`define CMD_ON_OFF_CONFIG   8'h02
`define CMD_CLEAR_FAULTS    8'h03
`define CMD_WRITE_PROTECT   8'h10
`define CMD_STORE_USER_ALL  8'h15
`define CMD_PLUS            8'hC8
`define CMD_DATA_PLUS_A     8'hC9
`define CMD_DATA_PLUS_B     8'hCA
`define CMD_GLOBAL_MASK     8'hE4
`define CMD_BASE_ADDR       8'hE6
// Default nonvolatile unlock code, overridable by parameter
`define CMD_NVM_UNLOCK_DFLT 8'hB0

// Protection register codes
`define WP_CODE_NONE        8'h00
`define WP_CODE_LEVEL2      8'h40
`define WP_CODE_LEVEL1      8'h80

// Page values
`define PAGE_GLOBAL         8'hFF
`define PAGE_MAX            5'h03

// Reset values
`define RST_PAGE            8'h00
`define RST_WRITE_PROTECT   8'h00
`define RST_GLOBAL_MASK     8'h0F
`define RST_BASE_ADDR       8'h5C

// Indirect command word fields
`define CP_HOST_BIT         14
`define CP_PAGE_HI          13
`define CP_PAGE_LO          9
`define CP_PTR_HI           8
`define CP_PTR_LO           0

// Register field widths
`define MASK_CH_W           4
`define BASE_ADDR_W         7

// Block read step in bytes per word read
`define BLK_STEP            8'h02

// Address select pin states
`define ASEL_LOW            2'b00
`define ASEL_FLOAT          2'b01
`define ASEL_HIGH           2'b10
`define ASEL_WEIGHT         4'h3

`endif

// file: core/pmbus_wp_pkg.sv
// Purpose: Types and shared decode functions
// Assumes: Constants header on the include path
// Notes:   Functions are used by the direct and indirect write paths
`include "pmbus_wp_consts.svh"

package pmbus_wp_pkg;

  // Effective protection level
  typedef enum logic [1:0] {
    WP_LVL_NONE = 2'b00,
    WP_LVL_2    = 2'b01,
    WP_LVL_1    = 2'b10
  } wp_level_t;

  // Transaction sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEM  = 2'b10
  } fsm_state_t;

  // Write permission for a command code under a protection level
  function automatic logic write_allowed(input wp_level_t lvl, input logic [7:0] code,
                                         input logic [7:0] unlock_code);
    logic ok;
    ok = 1'b0;
    case (lvl)
      WP_LVL_NONE: ok = 1'b1;
      WP_LVL_1:    ok = (code == `CMD_WRITE_PROTECT) || (code == `CMD_PAGE);
      WP_LVL_2:    ok = (code == `CMD_WRITE_PROTECT) || (code == `CMD_PAGE) ||
                        (code == unlock_code) || (code == `CMD_STORE_USER_ALL) ||
                        (code == `CMD_OPERATION) || (code == `CMD_GLOBAL_MASK) ||
                        (code == `CMD_CLEAR_FAULTS);
      default:     ok = 1'b0;
    endcase
    return ok;
  endfunction

  // One-hot channel select from a page number
  function automatic logic [3:0] chan_of(input logic [1:0] pg);
    logic [3:0] one;
    one = 4'h1;
    return one << pg;
  endfunction

endpackage : pmbus_wp_pkg

// file: core/wp_level_decode.sv
// Purpose: Effective write-protection level from pin and register
// Assumes: Pin synchronous to the clock
// Notes:   Purely combinational, no state
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_wp_consts.svh"

module wp_level_decode (
  input  wire logic [7:0]              wp_reg_i,
  input  wire logic                    wp_pin_i,
  output pmbus_wp_pkg::wp_level_t      level_o
);
  import pmbus_wp_pkg::*;

  // Most restrictive of pin and register wins
  always_comb begin
    if (wp_reg_i == `WP_CODE_LEVEL1) begin
      level_o = WP_LVL_1;
    end else if (wp_pin_i || (wp_reg_i == `WP_CODE_LEVEL2)) begin
      level_o = WP_LVL_2;
    end else begin
      level_o = WP_LVL_NONE;
    end
  end
endmodule // wp_level_decode

`default_nettype wire

// file: core/slave_addr_gen.sv
// Purpose: Device address from base plus pin-selected offset, and address match
// Assumes: Select pins give low, float or high as two-bit codes
// Notes:   Offset is high-pin state times three plus low-pin state
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_wp_consts.svh"

module slave_addr_gen (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic [6:0]              base_i,
  input  wire logic [1:0]              addr_select_hi_i,
  input  wire logic [1:0]              addr_select_lo_i,
  input  wire logic [6:0]              bus_addr_i,
  input  wire logic                    bus_addr_valid_i,
  output logic      [6:0]              dev_addr_o,
  output logic                         addr_hit_o
);
  import pmbus_wp_pkg::*;

  typedef struct packed {
    logic [6:0] dev_addr;
    logic       hit;
  } ag_state_t;

  ag_state_t st_r;
  ag_state_t st_nxt;
  logic [3:0] hi_w;
  logic [3:0] lo_w;
  logic [3:0] offset;

  // Pin state to weight, undefined code counts as high
  always_comb begin
    hi_w = (addr_select_hi_i == `ASEL_LOW)   ? 4'h0 :
           (addr_select_hi_i == `ASEL_FLOAT) ? 4'h1 : 4'h2;
    lo_w = (addr_select_lo_i == `ASEL_LOW)   ? 4'h0 :
           (addr_select_lo_i == `ASEL_FLOAT) ? 4'h1 : 4'h2;
    offset = 4'((hi_w * `ASEL_WEIGHT) + lo_w);
  end

  // Address sum and match on the live address
  always_comb begin
    st_nxt          = st_r;
    st_nxt.dev_addr = 7'(base_i + {3'h0, offset});
    st_nxt.hit      = bus_addr_valid_i && (bus_addr_i == st_nxt.dev_addr);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dev_addr_o = st_r.dev_addr;
  assign addr_hit_o = st_r.hit;
endmodule // slave_addr_gen

`default_nettype wire

// file: core/pmbus_write_protect_addressing.sv
// Purpose: Command gatekeeping, global page mask, indirect host access, device address
// Assumes: A bus front end hands over decoded byte/word commands; memory answers in the access cycle
// Notes:   Refused writes still answer; responses one cycle after local, two after memory access
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_wp_consts.svh"

module pmbus_write_protect_addressing #(
  parameter logic [7:0] NVM_UNLOCK_CODE = `CMD_NVM_UNLOCK_DFLT
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic [7:0]              req_code_i,
  input  wire logic [15:0]             req_wdata_i,
  input  wire logic                    req_paged_i,
  output logic                         req_ready_o,
  output logic                         rsp_valid_o,
  output logic      [15:0]             rsp_data_o,
  output logic                         rsp_refused_o,
  output logic                         comm_fault_o,
  input  wire logic                    write_protect_pin_i,
  output pmbus_wp_pkg::wp_level_t      wp_level_o,
  output logic                         mem_rd_o,
  output logic                         mem_wr_o,
  output logic      [8:0]              mem_addr_o,
  output logic      [3:0]              mem_chan_o,
  output logic      [7:0]              mem_index_o,
  output logic      [15:0]             mem_wdata_o,
  input  wire logic [15:0]             mem_rdata_i,
  output logic      [1:0]              poke_failed_o,
  input  wire logic [1:0]              addr_select_hi_i,
  input  wire logic [1:0]              addr_select_lo_i,
  input  wire logic [6:0]              bus_addr_i,
  input  wire logic                    bus_addr_valid_i,
  output logic      [6:0]              dev_addr_o,
  output logic                         addr_hit_o
);
  import pmbus_wp_pkg::*;

  typedef struct packed {
    fsm_state_t       state;
    logic             ready;
    logic [7:0]       page;
    logic [7:0]       wp;
    logic [7:0]       mask;
    logic [7:0]       base;
    wp_level_t        level;
    logic [1:0][4:0]  hpage;
    logic [1:0][8:0]  hptr;
    logic [1:0][7:0]  hidx;
    logic [1:0]       poke_fail;
    logic             pend_peek;
    logic             pend_host;
    logic             mem_rd;
    logic             mem_wr;
    logic [8:0]       mem_addr;
    logic [3:0]       mem_chan;
    logic [7:0]       mem_index;
    logic [15:0]      mem_wdata;
    logic             rsp_valid;
    logic [15:0]      rsp_data;
    logic             rsp_refused;
    logic             comm_fault;
  } blk_state_t;

  blk_state_t st_r;
  blk_state_t st_nxt;
  wp_level_t  level_w;
  logic       take;
  logic       host;
  logic       is_global;
  logic       global_ok;
  logic       poke_ok;

  // Effective protection level
  wp_level_decode u_wp_level (
    .wp_reg_i (st_r.wp),
    .wp_pin_i (write_protect_pin_i),
    .level_o  (level_w)
  );

  // Device address generation and match
  slave_addr_gen u_addr (
    .clk_i            (clk_i),
    .rst_b_i          (rst_b_i),
    .base_i           (st_r.base[6:0]),
    .addr_select_hi_i (addr_select_hi_i),
    .addr_select_lo_i (addr_select_lo_i),
    .bus_addr_i       (bus_addr_i),
    .bus_addr_valid_i (bus_addr_valid_i),
    .dev_addr_o       (dev_addr_o),
    .addr_hit_o       (addr_hit_o)
  );

  // Request decode helpers
  always_comb begin
    take      = req_valid_i && st_r.ready;
    host      = (req_code_i == `CMD_DATA_PLUS_B);
    is_global = (st_r.page == `PAGE_GLOBAL);
    global_ok = (req_code_i == `CMD_CLEAR_FAULTS) || (req_code_i == `CMD_OPERATION) ||
                (req_code_i == `CMD_ON_OFF_CONFIG);
    poke_ok   = (st_r.hpage[host] <= `PAGE_MAX) && !st_r.hptr[host][8] &&
                write_allowed(level_w, st_r.hptr[host][7:0], NVM_UNLOCK_CODE);
  end

  // Next-state logic for the whole block
  always_comb begin
    st_nxt             = st_r;
    st_nxt.level       = level_w;
    st_nxt.mem_rd      = 1'b0;
    st_nxt.mem_wr      = 1'b0;
    st_nxt.rsp_valid   = 1'b0;
    st_nxt.rsp_refused = 1'b0;
    st_nxt.comm_fault  = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        if (take && req_write_i) begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data  = 16'h0000;
          case (req_code_i)
            `CMD_PAGE: begin
              st_nxt.page = req_wdata_i[7:0];
            end
            `CMD_WRITE_PROTECT: begin
              st_nxt.wp = req_wdata_i[7:0];
            end
            `CMD_GLOBAL_MASK: begin
              if (write_allowed(level_w, req_code_i, NVM_UNLOCK_CODE)) begin
                st_nxt.mask = {4'h0, req_wdata_i[`MASK_CH_W-1:0]};
              end else begin
                st_nxt.rsp_refused = 1'b1;
              end
            end
            `CMD_BASE_ADDR: begin
              if (write_allowed(level_w, req_code_i, NVM_UNLOCK_CODE)) begin
                st_nxt.base = {1'b0, req_wdata_i[`BASE_ADDR_W-1:0]};
              end else begin
                st_nxt.rsp_refused = 1'b1;
              end
            end
            `CMD_PLUS: begin
              // Cache page and pointer for the selected host only
              st_nxt.hpage[req_wdata_i[`CP_HOST_BIT]] = req_wdata_i[`CP_PAGE_HI:`CP_PAGE_LO];
              st_nxt.hptr[req_wdata_i[`CP_HOST_BIT]]  = req_wdata_i[`CP_PTR_HI:`CP_PTR_LO];
              st_nxt.hidx[req_wdata_i[`CP_HOST_BIT]]  = 8'h00;
            end
            `CMD_DATA_PLUS_A, `CMD_DATA_PLUS_B: begin
              // Poke with the host's own page, main page untouched
              if (poke_ok) begin
                st_nxt.state           = ST_MEM;
                st_nxt.ready           = 1'b0;
                st_nxt.rsp_valid       = 1'b0;
                st_nxt.mem_wr          = 1'b1;
                st_nxt.mem_addr        = st_r.hptr[host];
                st_nxt.mem_chan        = chan_of(st_r.hpage[host][1:0]);
                st_nxt.mem_index       = 8'h00;
                st_nxt.mem_wdata       = req_wdata_i;
                st_nxt.poke_fail[host] = 1'b0;
              end else begin
                st_nxt.poke_fail[host] = 1'b1;
                st_nxt.rsp_refused     = 1'b1;
              end
            end
            default: begin
              if (is_global && !global_ok) begin
                st_nxt.comm_fault  = 1'b1;
                st_nxt.rsp_refused = 1'b1;
              end else if (!write_allowed(level_w, req_code_i, NVM_UNLOCK_CODE)) begin
                st_nxt.rsp_refused = 1'b1;
              end else begin
                st_nxt.state     = ST_MEM;
                st_nxt.ready     = 1'b0;
                st_nxt.rsp_valid = 1'b0;
                st_nxt.mem_wr    = 1'b1;
                st_nxt.mem_addr  = {1'b0, req_code_i};
                st_nxt.mem_index = 8'h00;
                st_nxt.mem_wdata = req_wdata_i;
                if (is_global) begin
                  st_nxt.mem_chan = st_r.mask[`MASK_CH_W-1:0];
                end else if (req_paged_i) begin
                  st_nxt.mem_chan = chan_of(st_r.page[1:0]);
                end else begin
                  st_nxt.mem_chan = 4'h0;
                end
              end
            end
          endcase
        end else if (take) begin
          // Reads are never screened by protection
          st_nxt.rsp_valid = 1'b1;
          case (req_code_i)
            `CMD_PAGE:          st_nxt.rsp_data = {8'h00, st_r.page};
            `CMD_WRITE_PROTECT: st_nxt.rsp_data = {8'h00, st_r.wp};
            `CMD_GLOBAL_MASK:   st_nxt.rsp_data = {8'h00, st_r.mask};
            `CMD_BASE_ADDR:     st_nxt.rsp_data = {8'h00, st_r.base};
            `CMD_PLUS:          st_nxt.rsp_data = 16'h0000;
            `CMD_DATA_PLUS_A, `CMD_DATA_PLUS_B: begin
              // Peek or block read through the host's cached pointer
              st_nxt.state     = ST_MEM;
              st_nxt.ready     = 1'b0;
              st_nxt.rsp_valid = 1'b0;
              st_nxt.mem_rd    = 1'b1;
              st_nxt.mem_addr  = st_r.hptr[host];
              st_nxt.mem_chan  = chan_of(st_r.hpage[host][1:0]);
              st_nxt.mem_index = st_r.hidx[host];
              st_nxt.pend_peek = 1'b1;
              st_nxt.pend_host = host;
            end
            default: begin
              if (is_global && req_paged_i) begin
                st_nxt.comm_fault = 1'b1;
                st_nxt.rsp_data   = 16'h0000;
              end else begin
                st_nxt.state     = ST_MEM;
                st_nxt.ready     = 1'b0;
                st_nxt.rsp_valid = 1'b0;
                st_nxt.mem_rd    = 1'b1;
                st_nxt.mem_addr  = {1'b0, req_code_i};
                st_nxt.mem_chan  = req_paged_i ? chan_of(st_r.page[1:0]) : 4'h0;
                st_nxt.mem_index = 8'h00;
                st_nxt.pend_peek = 1'b0;
              end
            end
          endcase
        end
      end
      ST_MEM: begin
        // Memory access cycle; capture data and answer next cycle
        st_nxt.state     = ST_IDLE;
        st_nxt.ready     = 1'b1;
        st_nxt.rsp_valid = 1'b1;
        st_nxt.rsp_data  = st_r.mem_rd ? mem_rdata_i : 16'h0000;
        if (st_r.mem_rd && st_r.pend_peek) begin
          st_nxt.hidx[st_r.pend_host] = 8'(st_r.hidx[st_r.pend_host] + `BLK_STEP);
        end
        st_nxt.pend_peek = 1'b0;
      end
      default: begin
        st_nxt.state = ST_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r           <= '0;
      st_r.state     <= ST_IDLE;
      st_r.ready     <= 1'b1;
      st_r.page      <= `RST_PAGE;
      st_r.wp        <= `RST_WRITE_PROTECT;
      st_r.mask      <= `RST_GLOBAL_MASK;
      st_r.base      <= `RST_BASE_ADDR;
      st_r.level     <= WP_LVL_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign req_ready_o   = st_r.ready;
  assign rsp_valid_o   = st_r.rsp_valid;
  assign rsp_data_o    = st_r.rsp_data;
  assign rsp_refused_o = st_r.rsp_refused;
  assign comm_fault_o  = st_r.comm_fault;
  assign wp_level_o    = st_r.level;
  assign mem_rd_o      = st_r.mem_rd;
  assign mem_wr_o      = st_r.mem_wr;
  assign mem_addr_o    = st_r.mem_addr;
  assign mem_chan_o    = st_r.mem_chan;
  assign mem_index_o   = st_r.mem_index;
  assign mem_wdata_o   = st_r.mem_wdata;
  assign poke_failed_o = st_r.poke_fail;
endmodule // pmbus_write_protect_addressing

`default_nettype wire

// file: tb/pmbus_wp_checker_properties.sv
// Purpose: Port-level temporal checks for the gatekeeping block
// Assumes: One clock domain, select pins held steady while addresses are probed
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_wp_consts.svh"
module pmbus_wp_checker
  import pmbus_wp_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    req_valid_i,
  input wire logic                    req_write_i,
  input wire logic [7:0]              req_code_i,
  input wire logic                    req_ready_o,
  input wire logic                    rsp_valid_o,
  input wire logic [15:0]             rsp_data_o,
  input wire logic                    rsp_refused_o,
  input wire logic                    comm_fault_o,
  input wire logic                    write_protect_pin_i,
  input wire pmbus_wp_pkg::wp_level_t wp_level_o,
  input wire logic                    mem_rd_o,
  input wire logic                    mem_wr_o,
  input wire logic [6:0]              bus_addr_i,
  input wire logic                    bus_addr_valid_i,
  input wire logic [6:0]              dev_addr_o,
  input wire logic                    addr_hit_o
);
  logic taken;
  // Request accepted at this edge
  assign taken = req_valid_i && req_ready_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Memory access drops ready once, then answers
  a_mem_answer: assert property (
    (mem_rd_o || mem_wr_o) |-> !req_ready_o ##1 (rsp_valid_o && req_ready_o))
    else $error("memory access not answered");
  // Every taken request is answered
  a_any_answer: assert property (taken |-> ##[1:2] rsp_valid_o)
    else $error("request never answered");
  // Refusal never follows a memory write
  a_refused_nowr: assert property (rsp_refused_o |-> rsp_valid_o && !mem_wr_o && !$past(mem_wr_o))
    else $error("refused write reached memory");
  // Fault answers carry zero data
  a_fault_zero: assert property (comm_fault_o |-> rsp_valid_o && rsp_data_o == 16'h0000)
    else $error("fault without zero answer");
  // Pin forces a protected level
  a_pin_level: assert property (
    $past(rst_b_i) && $past(write_protect_pin_i) |-> wp_level_o != WP_LVL_NONE)
    else $error("pin high but level none");
  // Reads are never refused
  a_read_ok: assert property (taken && !req_write_i |-> ##[1:2] (rsp_valid_o && !rsp_refused_o))
    else $error("read refused");
  // Protection and page selector stay writable
  a_wp_write_ok: assert property (
    taken && req_write_i && (req_code_i == `CMD_WRITE_PROTECT || req_code_i == `CMD_PAGE)
    |=> rsp_valid_o && !rsp_refused_o)
    else $error("protection or page write refused");
  // Hit only for a valid matching address
  a_addr_hit: assert property (
    addr_hit_o |-> $past(bus_addr_valid_i) && $past(bus_addr_i) == dev_addr_o)
    else $error("address hit without match");
  cover property (taken && req_write_i ##1 rsp_refused_o);
  cover property (comm_fault_o);
  cover property (mem_rd_o);
  cover property (addr_hit_o);
endmodule // pmbus_wp_checker

bind pmbus_write_protect_addressing pmbus_wp_checker u_pmbus_wp_checker (
  .clk_i, .rst_b_i, .req_valid_i, .req_write_i, .req_code_i, .req_ready_o, .rsp_valid_o, .rsp_data_o,
  .rsp_refused_o, .comm_fault_o, .write_protect_pin_i, .wp_level_o, .mem_rd_o, .mem_wr_o, .bus_addr_i,
  .bus_addr_valid_i, .dev_addr_o, .addr_hit_o);
`default_nettype wire

// file: tb/mem_model.sv
// Purpose: Rest-of-chip responder behind the memory port
// Assumes: Read data is due in the cycle of the read pulse
// Notes:   Outside reads it shows the inverse of the last answer
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [8:0]  mem_addr_i,
  input  wire logic [3:0]  mem_chan_i,
  input  wire logic [7:0]  mem_index_i,
  input  wire logic [15:0] mem_wdata_i,
  output logic      [15:0] mem_rdata_o
);
  logic [15:0] last_r = 16'h0000;
  int unsigned wr_cnt = 0;
  logic [3:0]  wr_chan = 4'h0;
  logic [8:0]  wr_addr = 9'h000;
  logic [15:0] wr_data = 16'h0000;
  // Answer carries channel, index and pointer so the bench can trace it
  assign mem_rdata_o = mem_rd_i ? {mem_chan_i, mem_index_i[3:0], mem_addr_i[7:0]} : ~last_r;
  // Keep the last answer and log writes
  always_ff @(posedge clk_i) begin
    if (mem_rd_i) begin
      last_r <= mem_rdata_o;
    end
    if (mem_wr_i) begin
      wr_cnt  <= wr_cnt + 1;
      wr_chan <= mem_chan_i;
      wr_addr <= mem_addr_i;
      wr_data <= mem_wdata_i;
    end
  end
endmodule // mem_model
`default_nettype wire

// file: tb/pmbus_write_protect_addressing_tb_top.sv
// Purpose: Directed bench for gatekeeping, global mask, indirect access, addressing
// Assumes: Memory responder answers in the read cycle
// Notes:   Requests driven by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_wp_consts.svh"
module pmbus_write_protect_addressing_tb_top;
  import pmbus_wp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic        req_paged_i = 1'b0;
  logic        write_protect_pin_i = 1'b0;
  logic        bus_addr_valid_i = 1'b0;
  logic [7:0]  req_code_i = 8'h00;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0]  addr_select_hi_i = 2'b00;
  logic [1:0]  addr_select_lo_i = 2'b00;
  logic [6:0]  bus_addr_i = 7'h00;
  logic        req_ready_o, rsp_valid_o, rsp_refused_o, comm_fault_o, mem_rd_o, mem_wr_o, addr_hit_o, rf, cf;
  logic [15:0] rsp_data_o, mem_wdata_o, mem_rdata_i, rd;
  logic [8:0]  mem_addr_o;
  logic [7:0]  mem_index_o;
  logic [3:0]  mem_chan_o;
  logic [1:0]  poke_failed_o;
  logic [6:0]  dev_addr_o;
  wp_level_t   wp_level_o;
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;

  pmbus_write_protect_addressing u_pmbus_write_protect_addressing (
    .clk_i, .rst_b_i, .req_valid_i, .req_write_i, .req_code_i, .req_wdata_i, .req_paged_i, .req_ready_o,
    .rsp_valid_o, .rsp_data_o, .rsp_refused_o, .comm_fault_o, .write_protect_pin_i, .wp_level_o, .mem_rd_o,
    .mem_wr_o, .mem_addr_o, .mem_chan_o, .mem_index_o, .mem_wdata_o, .mem_rdata_i, .poke_failed_o,
    .addr_select_hi_i, .addr_select_lo_i, .bus_addr_i, .bus_addr_valid_i, .dev_addr_o, .addr_hit_o);
  mem_model u_mem_model (.clk_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
    .mem_chan_i(mem_chan_o), .mem_index_i(mem_index_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  // Clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One request, held until taken, answer captured
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_code_i <= c;
    req_wdata_i <= d;
    req_paged_i <= p;
    do begin @(posedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 8);
    req_valid_i <= 1'b0;
    do begin @(posedge clk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 16);
    chk(rsp_valid_o, 1'b1);
    rd = rsp_data_o;
    rf = rsp_refused_o;
    cf = comm_fault_o;
  endtask

  task automatic t_reset();
    xfer(0, `CMD_WRITE_PROTECT, 0, 0);
    chk(rd, 16'h0000);
    xfer(0, `CMD_BASE_ADDR, 0, 0);
    chk(rd, 16'h005C);
  endtask

  // Every pin and protection code against a table of commands
  task automatic t_levels();
    logic [7:0]  codes [5] = '{`CMD_OPERATION, `CMD_CLEAR_FAULTS, `CMD_STORE_USER_ALL, `CMD_NVM_UNLOCK_DFLT, 8'h21};
    logic [7:0]  wpv [3] = '{`WP_CODE_NONE, `WP_CODE_LEVEL2, `WP_CODE_LEVEL1};
    logic [1:0]  lv;
    logic [15:0] em;
    int unsigned wc;
    logic        ok;
    em = 16'h000F;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        write_protect_pin_i <= p[0];
        xfer(1, `CMD_WRITE_PROTECT, {8'h00, wpv[k]}, 0);
        repeat (2) @(posedge clk_i);
        lv = (k == 2) ? 2'b10 : (p == 1 || k == 1) ? 2'b01 : 2'b00;
        chk(wp_level_o, lv);
        for (int i = 0; i < 5; i++) begin
          ok = (lv == 2'b00) || (lv == 2'b01 && i < 4);
          wc = u_mem_model.wr_cnt;
          xfer(1, codes[i], 16'h0011, 0);
          chk(rf, !ok);
          chk(16'(u_mem_model.wr_cnt - wc), 16'(ok));
        end
        xfer(0, `CMD_GLOBAL_MASK, 0, 0);
        chk(rd, em);
        xfer(1, `CMD_GLOBAL_MASK, 16'h00F0 + 16'(k + 1), 0);
        if (lv != 2'b10) em = 16'(k + 1);
        xfer(0, `CMD_GLOBAL_MASK, 0, 0);
        chk(rd, em);
        xfer(1, `CMD_PAGE, 16'h0000, 0);
        chk(rf, 1'b0);
      end
    end
    write_protect_pin_i <= 1'b0;
    xfer(1, `CMD_WRITE_PROTECT, 16'h0000, 0);
  endtask

  task automatic t_global();
    xfer(1, `CMD_GLOBAL_MASK, 16'h0005, 0);
    xfer(1, `CMD_PAGE, {8'h00, `PAGE_GLOBAL}, 0);
    xfer(1, `CMD_OPERATION, 16'h0080, 1);
    chk(u_mem_model.wr_chan, 4'h5);
    xfer(1, `CMD_GLOBAL_MASK, 16'h000A, 0);
    xfer(1, `CMD_ON_OFF_CONFIG, 16'h0001, 1);
    chk({rf, cf, u_mem_model.wr_chan}, 6'h0A);
    xfer(1, 8'h21, 16'h0001, 1);
    chk({rf, cf}, 2'b11);
    xfer(0, 8'h21, 0, 1);
    chk(cf, 1'b1);
    xfer(1, `CMD_PAGE, 16'h0001, 0);
  endtask

  // Two extra hosts peek and poke with their own pages
  task automatic t_indirect();
    xfer(1, `CMD_PLUS, {1'b0, 1'b0, 5'd2, 9'h021}, 0);
    xfer(1, `CMD_PLUS, {1'b0, 1'b1, 5'd3, 9'h030}, 0);
    for (int i = 0; i < 2; i++) begin
      xfer(0, `CMD_DATA_PLUS_A, 0, 0);
      chk(rd, {4'h4, 4'(2 * i), 8'h21});
    end
    xfer(0, `CMD_DATA_PLUS_B, 0, 0);
    chk(rd, 16'h8030);
    xfer(0, `CMD_PAGE, 0, 0);
    chk(rd, 16'h0001);
    xfer(1, `CMD_DATA_PLUS_A, 16'h1234, 0);
    chk(u_mem_model.wr_data, 16'h1234);
    chk({u_mem_model.wr_chan, u_mem_model.wr_addr}, {4'h4, 9'h021});
    xfer(1, `CMD_PLUS, {2'b00, 5'd2, 9'h021}, 0);
    xfer(0, `CMD_DATA_PLUS_A, 0, 0);
    chk(rd, 16'h4021);
    xfer(1, `CMD_PLUS, {1'b0, 1'b1, 5'd5, 9'h030}, 0);
    xfer(1, `CMD_DATA_PLUS_B, 16'h5678, 0);
    chk({rf, poke_failed_o}, 3'b110);
  endtask

  // All nine offsets, then a base with bit 7 set
  task automatic t_addr();
    logic [6:0] ea;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        addr_select_hi_i <= 2'(h);
        addr_select_lo_i <= 2'(l);
        ea = 7'h5C + 7'(3 * h + l);
        repeat (2) @(posedge clk_i);
        chk(dev_addr_o, ea);
        bus_addr_i <= ea;
        bus_addr_valid_i <= 1'b1;
        @(posedge clk_i);
        bus_addr_i <= ea + 7'h01;
        @(posedge clk_i);
        chk(addr_hit_o, 1'b1);
        bus_addr_i <= ea;
        bus_addr_valid_i <= 1'b0;
        @(posedge clk_i);
        chk(addr_hit_o, 1'b0);
        @(posedge clk_i);
        chk(addr_hit_o, 1'b0);
      end
    end
    xfer(1, `CMD_BASE_ADDR, 16'h0085, 0);
    xfer(0, `CMD_BASE_ADDR, 0, 0);
    chk(rd, 16'h0005);
    repeat (2) @(posedge clk_i);
    chk(dev_addr_o, 7'h0D);
  endtask

  task automatic summarize();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_levels();
    t_global();
    t_indirect();
    t_addr();
    summarize();
  end
endmodule // pmbus_write_protect_addressing_tb_top
`default_nettype wire
